//--- logic/smm_pkg.sv
package smm_pkg;
    // Instruction word, bit 0 is the most significant bit of the encoding
    localparam logic [5:0] OPC_PRIMARY = 6'h1f;
    localparam logic [9:0] XO_MOVE_SPR = 10'h1d3;
    localparam logic [8:0] XO_LEGACY_MUL = 9'h06b;
    // Special-purpose register numbers, after the half swap
    localparam logic [9:0] SPR_MULT_QUOT = 10'h000;
    localparam logic [9:0] SPR_FIXED_EXC = 10'h001;
    localparam logic [9:0] SPR_DECREMENTER = 10'h016;
    localparam logic [9:0] SPR_RTC_UPPER = 10'h014;
    localparam logic [9:0] SPR_RTC_LOWER = 10'h015;
    // Exception register bits in vector order (bit 0 of the encoding is [31])
    localparam int FXE_SUMMARY_POS = 31;
    localparam int FXE_OVERFLOW_POS = 30;
    localparam int FXE_CARRY_POS = 29;
    localparam logic [31:0] FXE_RESET = 32'h0000_0000;
    // Condition field 0
    localparam int CR_LESS_POS = 3;
    localparam int CR_GREATER_POS = 2;
    localparam int CR_EQUAL_POS = 1;
    localparam int CR_SUMMARY_POS = 0;
    localparam logic [3:0] CR0_RESET = 4'h0;
    // Avalon register map, byte addresses
    localparam logic [3:0] ADDR_CTRL = 4'h0;
    localparam logic [3:0] ADDR_STATUS = 4'h4;
    localparam logic [3:0] ADDR_MULT_QUOT = 4'h8;
    localparam logic [3:0] ADDR_FIXED_EXC = 4'hc;
    localparam int CTRL_LEGACY_POS = 0;
    localparam logic CTRL_LEGACY_RESET = 1'b1;

    typedef struct packed {
        logic        valid;
        logic [4:0]  idx;
        logic [31:0] data;
    } smm_gpr_wr_t;

    typedef struct packed {
        logic        valid;
        logic [9:0]  num;
        logic [31:0] data;
    } smm_spr_wr_t;

    // Registers that need supervisor state for a move-to
    function automatic logic smm_spr_priv(input logic [9:0] num);
        case (num)
            10'h012, 10'h013, SPR_DECREMENTER, 10'h019, 10'h01a, 10'h01b,
            SPR_RTC_UPPER, SPR_RTC_LOWER, 10'h11a, 10'h11c, 10'h11d: return 1'b1;
            default: return (num >= 10'h110 && num <= 10'h113) || (num >= 10'h210 && num <= 10'h21f);
        endcase
    endfunction

    function automatic logic smm_spr_known(input logic [9:0] num, input logic legacy);
        case (num)
            SPR_FIXED_EXC, 10'h008, 10'h009: return 1'b1;
            SPR_MULT_QUOT, SPR_RTC_UPPER, SPR_RTC_LOWER: return legacy;
            default: return smm_spr_priv(num);
        endcase
    endfunction
endpackage

//--- logic/smm_spr_mul_unit.sv
// Register access over Avalon-MM and the register offsets were left to the implementer.
`timescale 1ns/1ps
// Summary of operation
// - Opcode 31 with extended code 467 copies the source register into the named special register.
// - The special register number is the instruction's 10-bit field with its 5-bit halves swapped.
// - Numbers 0, 1, 8 and 9 need no privilege; the other listed numbers need supervisor state.
// - Moving to the decrementer is privileged in both variants; only the newer variant guards reads of it.
// - Numbers 0, 20 and 21 exist only in the legacy variant.
// - Any unlisted number is an invalid form and updates no register.
// - A special register move leaves the exception register and field 0 alone unless it targets that register.
// - The legacy multiply is opcode 31 with code 107 in bits 22-30, overflow enable at bit 21, record at bit 31.
// - The multiply puts product bits 0-31 in the target register and bits 32-63 in the quotient register.
// - No multiply form alters the carry bit.
// - With overflow enable set and a product that overflows 32 bits, overflow and summary overflow are set.
// - With record set, field 0 compares the low product word with zero and copies summary overflow.
// - Overflow enable clear leaves the exception register alone; record clear leaves field 0 alone.
module smm_spr_mul_unit
(
    // Clock and reset
    input  wire logic                 ref_clk_i,
    input  wire logic                 rst_i,
    // Issue stage
    input  wire logic                 issue_valid_i,
    input  wire logic [31:0]          instr_i,
    input  wire logic                 supervisor_i,
    input  wire logic [31:0]          op_s_i,
    input  wire logic [31:0]          op_a_i,
    input  wire logic [31:0]          op_b_i,
    // Register file writes and exceptions
    output smm_pkg::smm_gpr_wr_t      gpr_wr_o,
    output smm_pkg::smm_spr_wr_t      spr_wr_o,
    output logic [31:0]               mult_quot_o,
    output logic [31:0]               fixed_exc_o,
    output logic [3:0]                cr0_o,
    output logic                      cr0_wr_o,
    output logic                      priv_exc_o,
    output logic                      invalid_form_o,
    // Avalon-MM slave
    input  wire logic [3:0]           avs_address_i,
    input  wire logic                 avs_read_i,
    input  wire logic                 avs_write_i,
    input  wire logic [31:0]          avs_writedata_i,
    input  wire logic [3:0]           avs_byteenable_i,
    output logic [31:0]               avs_readdata_o,
    output logic                      avs_waitrequest_o
);
    logic                 legacy_reg;
    logic [31:0]          multiply_quotient_reg;
    logic [31:0]          fixed_point_exception_reg;
    logic [3:0]           cr0_reg;
    logic [7:0]           exec_cnt_reg;
    logic [7:0]           priv_cnt_reg;
    logic [7:0]           inval_cnt_reg;
    logic                 bus_ack_reg;
    logic [31:0]          rdata_reg;
    logic [31:0]          rdata_next;
    logic                 primary_hit;
    logic                 move_hit;
    logic                 mul_hit;
    logic [9:0]           spr_num;
    logic                 spr_known;
    logic                 spr_denied;
    logic                 move_go;
    logic                 ovf_enable;
    logic                 record_bit;
    logic signed [63:0]   product;
    logic                 mul_ovf;
    logic [31:0]          fxe_mul;
    logic [3:0]           cr_mul;

    assign primary_hit = instr_i[31:26] == smm_pkg::OPC_PRIMARY;
    assign move_hit = issue_valid_i && primary_hit && instr_i[10:1] == smm_pkg::XO_MOVE_SPR;
    assign mul_hit = issue_valid_i && primary_hit && instr_i[9:1] == smm_pkg::XO_LEGACY_MUL;
    assign ovf_enable = instr_i[10];
    assign record_bit = instr_i[0];
    assign spr_num = {instr_i[15:11], instr_i[20:16]};
    assign spr_known = smm_pkg::smm_spr_known(spr_num, legacy_reg);
    // Only move-to is executed here, so the decrementer is always guarded
    assign spr_denied = spr_known && smm_pkg::smm_spr_priv(spr_num) && !supervisor_i;
    assign move_go = move_hit && spr_known && !spr_denied;

    assign product = $signed(op_a_i) * $signed(op_b_i);
    assign mul_ovf = product[63:32] != {32{product[31]}};

    always_comb
    begin
        fxe_mul = fixed_point_exception_reg;
        fxe_mul[smm_pkg::FXE_OVERFLOW_POS] = mul_ovf;
        fxe_mul[smm_pkg::FXE_SUMMARY_POS] = fixed_point_exception_reg[smm_pkg::FXE_SUMMARY_POS] | mul_ovf;
        cr_mul[smm_pkg::CR_LESS_POS] = product[31];
        cr_mul[smm_pkg::CR_GREATER_POS] = !product[31] && (product[31:0] != 32'h0000_0000);
        cr_mul[smm_pkg::CR_EQUAL_POS] = product[31:0] == 32'h0000_0000;
        // Summary copy sees this instruction's own overflow update
        cr_mul[smm_pkg::CR_SUMMARY_POS] = ovf_enable ? fxe_mul[smm_pkg::FXE_SUMMARY_POS]
                                                     : fixed_point_exception_reg[smm_pkg::FXE_SUMMARY_POS];
    end

    always_ff @(posedge ref_clk_i or posedge rst_i)
    begin
        if (rst_i)
            fixed_point_exception_reg <= smm_pkg::FXE_RESET;
        else if (move_go && spr_num == smm_pkg::SPR_FIXED_EXC)
            fixed_point_exception_reg <= op_s_i;
        else if (mul_hit && ovf_enable)
            fixed_point_exception_reg <= fxe_mul;
    end

    always_ff @(posedge ref_clk_i or posedge rst_i)
    begin
        if (rst_i)
            multiply_quotient_reg <= 32'h0000_0000;
        else if (mul_hit)
            multiply_quotient_reg <= product[31:0];
        else if (move_go && spr_num == smm_pkg::SPR_MULT_QUOT)
            multiply_quotient_reg <= op_s_i;
    end

    always_ff @(posedge ref_clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            cr0_reg <= smm_pkg::CR0_RESET;
            cr0_wr_o <= 1'b0;
        end
        else
        begin
            cr0_wr_o <= mul_hit && record_bit;
            if (mul_hit && record_bit)
                cr0_reg <= cr_mul;
        end
    end

    always_ff @(posedge ref_clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            gpr_wr_o <= '0;
            spr_wr_o <= '0;
        end
        else
        begin
            gpr_wr_o.valid <= mul_hit;
            gpr_wr_o.idx <= instr_i[25:21];
            gpr_wr_o.data <= product[63:32];
            spr_wr_o.valid <= move_go;
            spr_wr_o.num <= spr_num;
            spr_wr_o.data <= op_s_i;
        end
    end

    always_ff @(posedge ref_clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            priv_exc_o <= 1'b0;
            invalid_form_o <= 1'b0;
        end
        else
        begin
            priv_exc_o <= move_hit && spr_denied;
            invalid_form_o <= move_hit && !spr_known;
        end
    end

    // Wrapping counters; software samples them twice to get a rate
    always_ff @(posedge ref_clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            exec_cnt_reg <= 8'h00;
            priv_cnt_reg <= 8'h00;
            inval_cnt_reg <= 8'h00;
        end
        else
        begin
            if (move_go || mul_hit)
                exec_cnt_reg <= exec_cnt_reg + 8'h01;
            if (move_hit && spr_denied)
                priv_cnt_reg <= priv_cnt_reg + 8'h01;
            if (move_hit && !spr_known)
                inval_cnt_reg <= inval_cnt_reg + 8'h01;
        end
    end

    // One wait state per access; read data is latched while waitrequest is high
    assign avs_waitrequest_o = (avs_read_i || avs_write_i) && !bus_ack_reg;
    assign avs_readdata_o = rdata_reg;

    always_comb
    begin
        case (avs_address_i)
            smm_pkg::ADDR_CTRL:      rdata_next = {31'h0000_0000, legacy_reg};
            smm_pkg::ADDR_STATUS:    rdata_next = {8'h00, inval_cnt_reg, priv_cnt_reg, exec_cnt_reg};
            smm_pkg::ADDR_MULT_QUOT: rdata_next = multiply_quotient_reg;
            smm_pkg::ADDR_FIXED_EXC: rdata_next = fixed_point_exception_reg;
            default:                 rdata_next = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge ref_clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            bus_ack_reg <= 1'b0;
            rdata_reg <= 32'h0000_0000;
        end
        else
        begin
            bus_ack_reg <= (avs_read_i || avs_write_i) && !bus_ack_reg;
            if (avs_read_i && !bus_ack_reg)
                rdata_reg <= rdata_next;
        end
    end

    // Changing the variant while instructions flow is allowed; it acts on the next issue
    always_ff @(posedge ref_clk_i or posedge rst_i)
    begin
        if (rst_i)
            legacy_reg <= smm_pkg::CTRL_LEGACY_RESET;
        else if (avs_write_i && bus_ack_reg && avs_address_i == smm_pkg::ADDR_CTRL && avs_byteenable_i[0])
            legacy_reg <= avs_writedata_i[smm_pkg::CTRL_LEGACY_POS];
    end

    assign mult_quot_o = multiply_quotient_reg;
    assign fixed_exc_o = fixed_point_exception_reg;
    assign cr0_o = cr0_reg;

    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (rst_i);

    a_move_copies_src: assert property (move_go |=> spr_wr_o.valid && spr_wr_o.data == $past(op_s_i))
        else $error("accepted move did not copy source");
    a_spr_half_swap: assert property (move_go |=> spr_wr_o.num == {$past(instr_i[15:11]), $past(instr_i[20:16])})
        else $error("register number halves not swapped");
    a_user_spr_ok: assert property (move_hit && !supervisor_i && (spr_num == 10'h008 || spr_num == 10'h009
        || spr_num == smm_pkg::SPR_FIXED_EXC) |=> spr_wr_o.valid && !priv_exc_o)
        else $error("unprivileged register refused");
    a_dec_write_priv: assert property (move_hit && !supervisor_i && spr_num == smm_pkg::SPR_DECREMENTER
        |=> priv_exc_o && !spr_wr_o.valid)
        else $error("user move to decrementer accepted");
    a_legacy_only_spr: assert property (move_hit && !legacy_reg && (spr_num == smm_pkg::SPR_MULT_QUOT
        || spr_num == smm_pkg::SPR_RTC_UPPER || spr_num == smm_pkg::SPR_RTC_LOWER) |=> invalid_form_o)
        else $error("legacy-only register accepted in newer variant");
    a_invalid_no_write: assert property (invalid_form_o |-> !spr_wr_o.valid && $stable(fixed_point_exception_reg)
        && $stable(multiply_quotient_reg))
        else $error("invalid form updated a register");
    a_move_keeps_flags: assert property (move_hit && spr_num != smm_pkg::SPR_FIXED_EXC
        |=> $stable(fixed_point_exception_reg) && $stable(cr0_reg) && !cr0_wr_o)
        else $error("move disturbed exception register or field 0");
    a_mul_decode: assert property (mul_hit |=> gpr_wr_o.valid && gpr_wr_o.idx == $past(instr_i[25:21]))
        else $error("multiply target not written");
    a_mul_split: assert property (mul_hit |=> {gpr_wr_o.data, multiply_quotient_reg}
        == {{32{$past(op_a_i[31])}}, $past(op_a_i)} * {{32{$past(op_b_i[31])}}, $past(op_b_i)})
        else $error("product words misplaced");
    a_mul_carry: assert property (mul_hit |=> $stable(fixed_point_exception_reg[smm_pkg::FXE_CARRY_POS]))
        else $error("multiply changed carry");
    a_mul_overflow: assert property (mul_hit && ovf_enable && mul_ovf |=> fixed_point_exception_reg[31:30] == 2'h3)
        else $error("overflow not recorded");
    a_mul_cr0: assert property (mul_hit && record_bit |=> cr0_wr_o && cr0_reg[smm_pkg::CR_EQUAL_POS]
        == (multiply_quotient_reg == 32'h0000_0000) && cr0_reg[smm_pkg::CR_LESS_POS] == multiply_quotient_reg[31]
        && cr0_reg[smm_pkg::CR_SUMMARY_POS] == fixed_point_exception_reg[smm_pkg::FXE_SUMMARY_POS])
        else $error("field 0 does not reflect low word");
    a_mul_no_oe: assert property (mul_hit && !ovf_enable |=> $stable(fixed_point_exception_reg))
        else $error("exception register touched with overflow enable clear");
    a_mul_no_rec: assert property (mul_hit && !record_bit |=> $stable(cr0_reg) && !cr0_wr_o)
        else $error("field 0 touched with record clear");
    a_priv_trap: assert property (move_hit && spr_denied |=> priv_exc_o && !spr_wr_o.valid ##1 !priv_exc_o
        || $past(move_hit && spr_denied))
        else $error("privileged move not trapped");

    c_move_accepted: cover property (move_go ##1 spr_wr_o.valid);
    c_priv_trap: cover property (move_hit && spr_denied ##1 priv_exc_o);
    c_mul_ovf_rec: cover property (mul_hit && ovf_enable && record_bit && mul_ovf);
    c_bus_read: cover property (avs_read_i && avs_waitrequest_o ##1 avs_read_i && !avs_waitrequest_o);
endmodule // smm_spr_mul_unit

//--- tb/smm_issue_model.sv
`timescale 1ns/1ps
module smm_issue_model
(
    // Clock and write-back
    input  wire logic            ref_clk_i,
    input  smm_pkg::smm_gpr_wr_t gpr_wr_i,
    // Issue
    output logic                 issue_valid_o = 1'b0,
    output logic [31:0]          instr_o = 32'h0,
    output logic                 supervisor_o = 1'b0,
    output logic [31:0]          op_s_o = 32'h0,
    output logic [31:0]          op_a_o = 32'h0,
    output logic [31:0]          op_b_o = 32'h0
);
    logic [31:0] gpr [32];
    logic [31:0] req_instr = 32'h0;
    logic        req_sup = 1'b0;
    logic        pend = 1'b0;

    // Idle operand buses toggle so a stale value is never taken for a live one
    always @(posedge ref_clk_i)
    begin
        issue_valid_o <= pend;
        instr_o       <= req_instr;
        supervisor_o  <= req_sup;
        op_s_o        <= pend ? gpr[req_instr[25:21]] : ~op_s_o;
        op_a_o        <= pend ? gpr[req_instr[20:16]] : ~op_a_o;
        op_b_o        <= pend ? gpr[req_instr[15:11]] : ~op_b_o;
        pend          <= 1'b0;
        if (gpr_wr_i.valid)
            gpr[gpr_wr_i.idx] <= gpr_wr_i.data;
    end

    // Returns in the cycle where the unit's answer stands
    task automatic issue(input logic [31:0] ins, input logic sup);
        @(negedge ref_clk_i);
        req_instr = ins;
        req_sup = sup;
        pend = 1'b1;
        repeat (2) @(posedge ref_clk_i);
        @(negedge ref_clk_i);
    endtask
endmodule // smm_issue_model

//--- tb/spr_move_and_multiply_bench.sv
`timescale 1ns/1ps
module spr_move_and_multiply_bench;
    logic                 ref_clk = 1'b0;
    logic                 rst = 1'b1;
    logic                 issue_valid;
    logic [31:0]          instr;
    logic                 supervisor;
    logic [31:0]          op_s;
    logic [31:0]          op_a;
    logic [31:0]          op_b;
    smm_pkg::smm_gpr_wr_t gpr_wr;
    smm_pkg::smm_spr_wr_t spr_wr;
    logic [31:0]          mult_quot;
    logic [31:0]          fixed_exc;
    logic [3:0]           cr0;
    logic                 cr0_wr;
    logic                 priv_exc;
    logic                 invalid_form;
    logic [3:0]           avs_address = 4'h0;
    logic                 avs_read = 1'b0;
    logic                 avs_write = 1'b0;
    logic [31:0]          avs_writedata = 32'h0;
    logic [31:0]          avs_readdata;
    logic                 avs_waitrequest;
    logic [31:0]          fxe_exp = 32'h0;
    logic [31:0]          mq_exp;
    logic [3:0]           cr_exp = 4'h0;
    int                   err_count = 0;
    int                   checks = 0;

    always #50 ref_clk = ~ref_clk;

    smm_spr_mul_unit dut (.ref_clk_i(ref_clk), .rst_i(rst), .issue_valid_i(issue_valid), .instr_i(instr),
        .supervisor_i(supervisor), .op_s_i(op_s), .op_a_i(op_a), .op_b_i(op_b), .gpr_wr_o(gpr_wr),
        .spr_wr_o(spr_wr), .mult_quot_o(mult_quot), .fixed_exc_o(fixed_exc), .cr0_o(cr0), .cr0_wr_o(cr0_wr),
        .priv_exc_o(priv_exc), .invalid_form_o(invalid_form), .avs_address_i(avs_address),
        .avs_read_i(avs_read), .avs_write_i(avs_write), .avs_writedata_i(avs_writedata),
        .avs_byteenable_i(4'hf), .avs_readdata_o(avs_readdata), .avs_waitrequest_o(avs_waitrequest));

    smm_issue_model model (.ref_clk_i(ref_clk), .gpr_wr_i(gpr_wr), .issue_valid_o(issue_valid),
        .instr_o(instr), .supervisor_o(supervisor), .op_s_o(op_s), .op_a_o(op_a), .op_b_o(op_b));

    task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
        checks++;
        if (seen !== exp)
        begin
            err_count++;
            $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic end_of_test();
        $display("comparisons %0d mismatches %0d", checks, err_count);
        if (err_count == 0 && checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    // Waitrequest and read data are taken at the rising edge, before that edge's updates land
    task automatic av(input logic wr, input logic [3:0] adr, input logic [31:0] wd, output logic [31:0] rd);
        int n;
        n = 0;
        @(posedge ref_clk);
        avs_write <= wr;
        avs_read <= !wr;
        avs_address <= adr;
        avs_writedata <= wd;
        do
        begin
            @(posedge ref_clk);
            n++;
        end
        while (avs_waitrequest !== 1'b0 && n < 20);
        rd = avs_readdata;
        if (n >= 20)
        begin
            err_count++;
            end_of_test();
        end
        avs_write <= 1'b0;
        avs_read <= 1'b0;
    endtask

    // Kind: 0 accepted, 1 privileged in user state, 2 number unknown in the current variant
    task automatic move_case(input logic [9:0] num, input logic sup, input logic [1:0] kind, input logic [31:0] d);
        logic [31:0] fxe_was;
        logic [31:0] mq_was;
        fxe_was = fixed_exc;
        mq_was = mult_quot;
        model.gpr[5] = d;
        model.issue({6'h1f, 5'h05, num[4:0], num[9:5], smm_pkg::XO_MOVE_SPR, 1'b0}, sup);
        chk(spr_wr.valid, kind == 2'h0);
        chk(priv_exc, kind == 2'h1);
        chk(invalid_form, kind == 2'h2);
        chk(cr0_wr, 1'b0);
        if (kind == 2'h0)
            chk({spr_wr.num, spr_wr.data}, {num, d});
        chk(fixed_exc, (kind == 2'h0 && num == smm_pkg::SPR_FIXED_EXC) ? d : fxe_was);
        chk(mult_quot, (kind == 2'h0 && num == smm_pkg::SPR_MULT_QUOT) ? d : mq_was);
    endtask

    task automatic mul_case(input logic [31:0] a, input logic [31:0] b, input logic oe, input logic rc);
        logic [63:0] p;
        logic        ovf;
        p = $signed(a) * $signed(b);
        ovf = p[63:32] != {32{p[31]}};
        mq_exp = p[31:0];
        model.gpr[4] = a;
        model.gpr[10] = b;
        if (oe)
        begin
            fxe_exp[30] = ovf;
            fxe_exp[31] = fxe_exp[31] | ovf;
        end
        if (rc)
            cr_exp = {p[31], !p[31] && p[31:0] != 32'h0, p[31:0] == 32'h0, fxe_exp[31]};
        model.issue({6'h1f, 5'h06, 5'h04, 5'h0a, oe, smm_pkg::XO_LEGACY_MUL, rc}, 1'b0);
        chk({gpr_wr.valid, gpr_wr.idx, gpr_wr.data}, {1'b1, 5'h06, p[63:32]});
        chk(mult_quot, p[31:0]);
        chk(fixed_exc, fxe_exp);
        chk({cr0_wr, cr0}, {rc, cr_exp});
    endtask

    task automatic t_move();
        move_case(10'd8, 1'b0, 2'h0, 32'h1000_00ff);
        move_case(10'd9, 1'b0, 2'h0, 32'hfedc_ba98);
        move_case(10'd0, 1'b0, 2'h0, 32'h0bad_cafe);
        move_case(10'd18, 1'b0, 2'h1, 32'h1);
        move_case(10'd272, 1'b0, 2'h1, 32'h2);
        move_case(10'd543, 1'b0, 2'h1, 32'h3);
        move_case(10'd20, 1'b0, 2'h1, 32'h4);
        move_case(10'd285, 1'b1, 2'h0, 32'h8765_4321);
        move_case(10'd528, 1'b1, 2'h0, 32'h0f0f_0f0f);
        move_case(10'd21, 1'b1, 2'h0, 32'h7777_0001);
        move_case(10'd23, 1'b1, 2'h2, 32'h5);
        move_case(10'd276, 1'b1, 2'h2, 32'h6);
        move_case(10'd544, 1'b1, 2'h2, 32'h7);
        $display("t_move done, mismatches %0d", err_count);
    endtask

    task automatic t_variant();
        logic [31:0] rd;
        av(1'b1, smm_pkg::ADDR_CTRL, 32'h0, rd);
        av(1'b0, smm_pkg::ADDR_CTRL, 32'h0, rd);
        chk(rd, 32'h0);
        move_case(10'd0, 1'b1, 2'h2, 32'h1);
        move_case(10'd20, 1'b1, 2'h2, 32'h1);
        move_case(10'd21, 1'b1, 2'h2, 32'h1);
        move_case(10'd22, 1'b0, 2'h1, 32'h1);
        move_case(10'd22, 1'b1, 2'h0, 32'h1);
        av(1'b1, smm_pkg::ADDR_CTRL, 32'h1, rd);
        av(1'b0, 4'h2, 32'h0, rd);
        chk(rd, 32'h0);
        $display("t_variant done, mismatches %0d", err_count);
    endtask

    task automatic t_mul();
        logic [31:0] rd;
        move_case(10'd1, 1'b0, 2'h0, 32'h2000_0000);
        fxe_exp = 32'h2000_0000;
        mul_case(32'h0000_4500, 32'h8000_7000, 1'b0, 1'b0);
        mul_case(32'h0000_4500, 32'h8000_7000, 1'b0, 1'b1);
        mul_case(32'h0000_4500, 32'h8000_7000, 1'b1, 1'b0);
        mul_case(32'h0000_4500, 32'h8000_7000, 1'b1, 1'b1);
        mul_case(32'h0000_0003, 32'h0000_0002, 1'b1, 1'b1);
        mul_case(32'hffff_ffff, 32'h0000_0002, 1'b0, 1'b1);
        mul_case(32'h0001_0000, 32'h0001_0000, 1'b1, 1'b1);
        mul_case(32'h8000_0000, 32'hffff_ffff, 1'b1, 1'b0);
        av(1'b0, smm_pkg::ADDR_MULT_QUOT, 32'h0, rd);
        chk(rd, mq_exp);
        av(1'b0, smm_pkg::ADDR_FIXED_EXC, 32'h0, rd);
        chk(rd, fxe_exp);
        $display("t_mul done, mismatches %0d", err_count);
    endtask

    initial
    begin
        repeat (4) @(posedge ref_clk);
        rst <= 1'b0;
        t_move();
        t_variant();
        t_mul();
        end_of_test();
    end
endmodule // spr_move_and_multiply_bench
